// File: include/lpv_consts.vh
// constants of the panel link controller: apb map, fields, resets, timing
// assumes a 250 MHz system clock and seven link slots per pixel clock
`ifndef LPV_CONSTS_VH
`define LPV_CONSTS_VH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define LPV_OFF_CTRL 12'h000
`define LPV_OFF_HBLANK 12'h004
`define LPV_OFF_VBLANK 12'h008
`define LPV_OFF_STATUS 12'h00c
`define LPV_OFF_FRAMES 12'h010

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define LPV_CTRL_RUN 0
`define LPV_CTRL_DEPTH8 1
`define LPV_CTRL_SCANREV 2
`define LPV_CTRL_JEIDA 3
`define LPV_CTRL_SUPPLY 4
`define LPV_CTRL_BACKLIGHT 5
`define LPV_CTRL_W 6
`define LPV_CTRL_RESET 6'h00

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define LPV_ST_RUNNING 0
`define LPV_ST_VALID 1
`define LPV_ST_BACKLIGHT 2
`define LPV_ST_LINE_LSB 16

// ----------------------------------------------------------------
// frame geometry in pixel clocks and lines
// ----------------------------------------------------------------
`define LPV_H_ACTIVE 11'h320
`define LPV_HB_MIN 9'h0aa
`define LPV_HB_MAX 9'h12c
`define LPV_HB_RESET 9'h0b0
`define LPV_V_ACTIVE 10'h258
`define LPV_VB_MIN 8'h0a
`define LPV_VB_MAX 8'ha0
`define LPV_VB_RESET 8'h0a

// ----------------------------------------------------------------
// link slots
// ----------------------------------------------------------------
`define LPV_SLOTS 7
`define LPV_SLOT_LAST 3'h6
`define LPV_CLK_PATTERN 7'h63

`endif

// File: rtl/lpv_lane_ser.v
// one link lane: loads a seven-slot word and sends it msb first
// assumes load arrives once every seven clocks from the parent
`timescale 1ns/1ps
module lpv_lane_ser
#(
  parameter SLOTS = 7
)
(
  input wire clk,
  input wire reset,
  input wire load,
  input wire [SLOTS-1:0] word,
  output reg bit_out
);

reg [SLOTS-1:0] shift_reg;

always @(posedge clk or posedge reset)
begin
  if (reset)
  begin
    shift_reg <= {SLOTS{1'b0}};
    bit_out <= 1'b0;
  end
  else if (load)
  begin
    bit_out <= word[SLOTS-1];
    shift_reg <= {word[SLOTS-2:0], 1'b0};
  end
  else
  begin
    bit_out <= shift_reg[SLOTS-1];
    shift_reg <= {shift_reg[SLOTS-2:0], 1'b0};
  end
end

endmodule // lpv_lane_ser

// File: rtl/lpv_host_ctrl.v
// host controller that drives the 800x600 panel's serial pixel link
// assumes apb on clk, a 24-bit pixel source answering pix_ready at once
//
// Functional notes
// (RQ1) Pixel clock 34 to 48 MHz, frames at 60 Hz.
// (RQ2) Line is 800 active clocks plus 170 to 300 blanking clocks.
// (RQ3) Frame is 600 active lines plus 10 to 160 whole blanking lines.
// (RQ4) Clock may be spread up to 1.5 percent at 25 to 90 kHz.
// (RQ5) Panel uses enable strobe only; both sync inputs held low.
// (RQ6) Each colour is unsigned 8 bits, bit 7 most significant.
// (RQ7) Depth select low: 6 bits on three lanes; high: fourth lane added.
// (RQ8) Scan direction select low normal, high flips both axes.
// (RQ9) Six-bit lane map: red and green0, green and blue, blue and enable.
// (RQ10) Lane format select unconnected means standard VESA ordering.
// (RQ11) Supply off: every interface input low or undriven, never high.
// (RQ12) Supply on: every interface signal actively driven; the code leaves the format select pin undriven in VESA mode.
// (RQ13) Backlight only while valid video is shown.
// (RQ14) Eight-bit VESA: lane 3 carries bits 6 and 7 of each colour.
// (RQ15) Format select grounded: JEIDA, upper six bits on lanes 0 to 2.
// (RQ16) Panel accepts pixels while enable high, 800 per line.
`timescale 1ns/1ps
`include "lpv_consts.vh"
module lpv_host_ctrl
#(
  parameter H_ACTIVE = 800,
  parameter V_ACTIVE = 600
)
(
  input wire clk,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [23:0] pix_rgb,
  output wire pix_ready,
  output reg frame_start,
  output reg [3:0] lane_pos,
  output reg [3:0] lane_neg,
  output reg link_clock_pos,
  output reg link_clock_neg,
  output reg line_sync_input,
  output reg frame_sync_input,
  output reg depth_select,
  output reg scan_direction_select,
  output reg lane_format_select_out,
  output reg lane_format_select_oe,
  output reg supply_enable,
  output reg backlight_enable
);

// ----------------------------------------------------------------
// register file
// ----------------------------------------------------------------
reg [`LPV_CTRL_W-1:0] ctrl_reg;
reg [8:0] hblank_reg;
reg [7:0] vblank_reg;
reg [15:0] frames_reg;
reg running_reg;
reg valid_reg;
reg [10:0] hpos_reg;
reg [9:0] vpos_reg;
reg [2:0] slot_reg;
reg [8:0] hblank_act_reg;
reg [7:0] vblank_act_reg;

wire wr_en = psel & penable & pwrite;
wire setup = psel & ~penable;

function mapped;
  input [11:0] a;
  begin
    mapped = (a == `LPV_OFF_CTRL) || (a == `LPV_OFF_HBLANK) ||
             (a == `LPV_OFF_VBLANK) || (a == `LPV_OFF_STATUS) ||
             (a == `LPV_OFF_FRAMES);
  end
endfunction

function [8:0] clamp_h;
  input [31:0] d;
  begin
    if (d < {23'h0, `LPV_HB_MIN})
      clamp_h = `LPV_HB_MIN;
    else if (d > {23'h0, `LPV_HB_MAX})
      clamp_h = `LPV_HB_MAX;
    else
      clamp_h = d[8:0];
  end
endfunction

function [7:0] clamp_v;
  input [31:0] d;
  begin
    if (d < {24'h0, `LPV_VB_MIN})
      clamp_v = `LPV_VB_MIN;
    else if (d > {24'h0, `LPV_VB_MAX})
      clamp_v = `LPV_VB_MAX;
    else
      clamp_v = d[7:0];
  end
endfunction

assign pready = 1'b1;
assign pslverr = psel & penable & ~mapped(paddr);

always @(posedge clk or posedge reset)
begin
  if (reset)
  begin
    ctrl_reg <= `LPV_CTRL_RESET;
    hblank_reg <= `LPV_HB_RESET;
    vblank_reg <= `LPV_VB_RESET;
  end
  else if (wr_en)
  begin
    case (paddr)
      `LPV_OFF_CTRL: ctrl_reg <= pwdata[`LPV_CTRL_W-1:0];
      `LPV_OFF_HBLANK: hblank_reg <= clamp_h(pwdata); // see (RQ2)
      `LPV_OFF_VBLANK: vblank_reg <= clamp_v(pwdata); // see (RQ3)
      default: ctrl_reg <= ctrl_reg;
    endcase
  end
end

// read data is captured in the setup cycle, ready in the access cycle
always @(posedge clk or posedge reset)
begin
  if (reset)
    prdata <= 32'h0000_0000;
  else if (setup)
  begin
    case (paddr)
      `LPV_OFF_CTRL: prdata <= {26'h0, ctrl_reg};
      `LPV_OFF_HBLANK: prdata <= {23'h0, hblank_reg};
      `LPV_OFF_VBLANK: prdata <= {24'h0, vblank_reg};
      `LPV_OFF_STATUS: prdata <= {6'h0, vpos_reg, 13'h0,
        backlight_enable, valid_reg, running_reg};
      `LPV_OFF_FRAMES: prdata <= {16'h0, frames_reg};
      default: prdata <= 32'h0000_0000;
    endcase
  end
end

// ----------------------------------------------------------------
// pixel timing
// ----------------------------------------------------------------
wire supply_on = ctrl_reg[`LPV_CTRL_SUPPLY];
wire run_req = ctrl_reg[`LPV_CTRL_RUN] & supply_on;
wire pix_edge = (slot_reg == `LPV_SLOT_LAST);
wire [10:0] h_total = H_ACTIVE[10:0] + {2'b00, hblank_act_reg}; // see (RQ2)
wire [9:0] v_total = V_ACTIVE[9:0] + {2'b00, vblank_act_reg}; // see (RQ3)
wire h_last = (hpos_reg == h_total - 11'h001);
wire v_last = (vpos_reg == v_total - 10'h001);
wire at_origin = (hpos_reg == 11'h000) && (vpos_reg == 10'h000);
// run bit decides at the origin edge itself: no orphan first pixel
// on stop, no lost first pixel on start
wire run_now = at_origin ? run_req : running_reg;
wire active = run_now && (hpos_reg < H_ACTIVE[10:0]) &&
  (vpos_reg < V_ACTIVE[9:0]); // see (RQ16)

// one slot per clock: 7 x 4 ns gives a 35.7 MHz pixel clock
always @(posedge clk or posedge reset) // see (RQ1)
begin
  if (reset)
    slot_reg <= 3'h0;
  else if (pix_edge)
    slot_reg <= 3'h0;
  else
    slot_reg <= slot_reg + 3'h1;
end

// ----------------------------------------------------------------
// geometry in use
// ----------------------------------------------------------------
// blanking written mid-frame waits for the frame origin, so no line
// is cut and the position never runs past its total
always @(posedge clk or posedge reset) // see (RQ3)
begin
  if (reset)
  begin
    hblank_act_reg <= `LPV_HB_RESET;
    vblank_act_reg <= `LPV_VB_RESET;
  end
  else if (pix_edge && at_origin)
  begin
    hblank_act_reg <= hblank_reg;
    vblank_act_reg <= vblank_reg;
  end
end

// run bit starts and stops output at the frame origin; supply off stops it at once
always @(posedge clk or posedge reset)
begin
  if (reset)
  begin
    hpos_reg <= 11'h000;
    vpos_reg <= 10'h000;
    running_reg <= 1'b0;
    valid_reg <= 1'b0;
    frames_reg <= 16'h0000;
    frame_start <= 1'b0;
  end
  else
  begin
    frame_start <= 1'b0;
    if (!supply_on)
    begin
      hpos_reg <= 11'h000;
      vpos_reg <= 10'h000;
      running_reg <= 1'b0;
      valid_reg <= 1'b0;
    end
    else if (pix_edge)
    begin
      if (at_origin)
      begin
        running_reg <= run_req;
        frame_start <= run_req;
        if (!run_req)
          valid_reg <= 1'b0;
      end
      if (h_last)
      begin
        hpos_reg <= 11'h000;
        if (v_last) // see (RQ3)
        begin
          vpos_reg <= 10'h000;
          if (running_reg)
          begin
            valid_reg <= 1'b1;
            frames_reg <= frames_reg + 16'h0001;
          end
        end
        else
          vpos_reg <= vpos_reg + 10'h001;
      end
      else if (run_now || !at_origin)
        hpos_reg <= hpos_reg + 11'h001;
    end
  end
end

// ----------------------------------------------------------------
// lane word packing
// ----------------------------------------------------------------
assign pix_ready = pix_edge & active; // see (RQ16)

wire depth8 = ctrl_reg[`LPV_CTRL_DEPTH8];
wire jeida = ctrl_reg[`LPV_CTRL_JEIDA] & depth8;
wire [7:0] red = active ? pix_rgb[23:16] : 8'h00; // see (RQ6)
wire [7:0] grn = active ? pix_rgb[15:8] : 8'h00;
wire [7:0] blu = active ? pix_rgb[7:0] : 8'h00;
// six bits on lanes 0..2: low six (vesa) or high six (jeida)
wire [5:0] r6 = jeida ? red[7:2] : red[5:0]; // see (RQ15)
wire [5:0] g6 = jeida ? grn[7:2] : grn[5:0];
wire [5:0] b6 = jeida ? blu[7:2] : blu[5:0];
wire [1:0] r2 = jeida ? red[1:0] : red[7:6]; // see (RQ14)
wire [1:0] g2 = jeida ? grn[1:0] : grn[7:6];
wire [1:0] b2 = jeida ? blu[1:0] : blu[7:6];

wire [`LPV_SLOTS-1:0] words [0:4];
assign words[0] = {g6[0], r6[5:0]}; // see (RQ9)
assign words[1] = {b6[1:0], g6[5:1]}; // see (RQ9)
assign words[2] = {active, 2'b00, b6[5:2]}; // see (RQ9)
assign words[3] = depth8 ? {1'b0, b2, g2, r2} : 7'h00; // see (RQ7)
assign words[4] = `LPV_CLK_PATTERN;

wire [4:0] lane_bits;
genvar i;
generate
  for (i = 0; i < 5; i = i + 1)
  begin : g_lane
    lpv_lane_ser #(
      .SLOTS(`LPV_SLOTS)
    ) u_lane (
      .clk(clk),
      .reset(reset),
      .load(pix_edge),
      .word(words[i]),
      .bit_out(lane_bits[i])
    );
  end
endgenerate

// ----------------------------------------------------------------
// pin drive
// ----------------------------------------------------------------
// a fixed divided clock has no spread; the panel tolerates it either way
always @(posedge clk or posedge reset) // see (RQ4)
begin
  if (reset)
  begin
    lane_pos <= 4'h0;
    lane_neg <= 4'h0;
    link_clock_pos <= 1'b0;
    link_clock_neg <= 1'b0;
    line_sync_input <= 1'b0;
    frame_sync_input <= 1'b0;
    depth_select <= 1'b0;
    scan_direction_select <= 1'b0;
    lane_format_select_out <= 1'b0;
    lane_format_select_oe <= 1'b1;
    supply_enable <= 1'b0;
    backlight_enable <= 1'b0;
  end
  else
  begin
    supply_enable <= supply_on;
    line_sync_input <= 1'b0; // see (RQ5)
    frame_sync_input <= 1'b0; // see (RQ5)
    lane_format_select_out <= 1'b0;
    if (supply_on) // see (RQ12)
    begin
      lane_pos <= lane_bits[3:0];
      lane_neg <= ~lane_bits[3:0];
      link_clock_pos <= lane_bits[4];
      link_clock_neg <= ~lane_bits[4];
      depth_select <= depth8; // see (RQ7)
      scan_direction_select <= ctrl_reg[`LPV_CTRL_SCANREV]; // see (RQ8)
      // vesa: pin left open; jeida: pin grounded
      lane_format_select_oe <= jeida; // see (RQ10)
    end
    else // see (RQ11)
    begin
      lane_pos <= 4'h0;
      lane_neg <= 4'h0;
      link_clock_pos <= 1'b0;
      link_clock_neg <= 1'b0;
      depth_select <= 1'b0;
      scan_direction_select <= 1'b0;
      lane_format_select_oe <= 1'b1;
    end
    backlight_enable <= ctrl_reg[`LPV_CTRL_BACKLIGHT] & run_req &
      valid_reg; // see (RQ13)
  end
end

endmodule // lpv_host_ctrl

// File: tb/lpv_host_ctrl_checker.sv
// checker: port assertions for the panel link controller
// assumes a bind onto lpv_host_ctrl, one clock domain
`timescale 1ns/1ps
module lpv_host_ctrl_checker
#(
  parameter H_ACTIVE = 800,
  parameter V_ACTIVE = 600
)
(
  input wire clk,
  input wire reset,
  input wire pix_ready,
  input wire frame_start,
  input wire [3:0] lane_pos,
  input wire [3:0] lane_neg,
  input wire link_clock_pos,
  input wire link_clock_neg,
  input wire line_sync_input,
  input wire frame_sync_input,
  input wire depth_select,
  input wire supply_enable,
  input wire backlight_enable
);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_sync_held_low:
    assert property (!line_sync_input && !frame_sync_input)
    else $error("sync input driven high");
  a_pixel_spacing:
    assert property (pix_ready |=> !pix_ready [*6])
    else $error("pixels closer than seven slots");
  a_clock_shape:
    assert property (disable iff (reset || !supply_enable)
      $fell(link_clock_pos) |-> !link_clock_pos [*3] ##1
      link_clock_pos [*4] ##1 !link_clock_pos)
    else $error("link clock pattern wrong");
  a_frame_origin:
    assert property (frame_start |-> $past(pix_ready) ##1 !frame_start)
    else $error("frame start not on first pixel");
  a_lane_complement:
    assert property (supply_enable && $past(supply_enable, 2) |->
      lane_neg == ~lane_pos && link_clock_neg != link_clock_pos)
    else $error("lane pair not complementary");
  a_supply_off_low:
    assert property (!supply_enable && !$past(supply_enable, 3) |->
      lane_pos == 4'h0 && lane_neg == 4'h0 && !link_clock_pos
      && !link_clock_neg)
    else $error("link driven while supply off");
  a_backlight_supply:
    assert property (backlight_enable |-> supply_enable)
    else $error("backlight on without supply");
  a_depth_lane3:
    assert property (supply_enable && !depth_select &&
      !$past(depth_select, 16) |-> !lane_pos[3])
    else $error("fourth lane busy in six-bit mode");
  cover property (frame_start);
  cover property ($fell(backlight_enable));
  cover property (pix_ready && !depth_select);
endmodule // lpv_host_ctrl_checker

bind lpv_host_ctrl lpv_host_ctrl_checker #(
  .H_ACTIVE(H_ACTIVE),
  .V_ACTIVE(V_ACTIVE)
) lpv_host_ctrl_checker_inst (.clk, .reset, .pix_ready, .frame_start,
  .lane_pos, .lane_neg, .link_clock_pos, .link_clock_neg,
  .line_sync_input, .frame_sync_input, .depth_select, .supply_enable,
  .backlight_enable);

// File: tb/lpv_panel_model.sv
// panel model: gathers link words, decodes pixels, checks framing
// assumes link pins sampled on the controller clock, one slot a clock
`timescale 1ns/1ps
`include "lpv_consts.vh"
module lpv_panel_model
#(
  parameter H_ACTIVE = 800,
  parameter V_ACTIVE = 600
)
(
  input wire clk,
  input wire reset,
  input wire [3:0] lane_pos,
  input wire link_clock_pos,
  input wire line_sync_input,
  input wire frame_sync_input,
  input wire depth_select,
  input wire scan_direction_select,
  input wire lane_format_select_out,
  input wire lane_format_select_oe,
  output reg px_valid,
  output reg [23:0] px_rgb,
  output reg [10:0] px_col,
  output reg [7:0] errs
);
  // ----------------------------------------------------------------
  // word capture and decode
  // ----------------------------------------------------------------
  reg [6:0] sc_reg, s0_reg, s1_reg, s2_reg, s3_reg;
  reg [10:0] x_reg;
  reg [15:0] gap_reg;
  reg [9:0] lines_reg;
  wire [6:0] t3 = depth_select ? s3_reg : 7'h00;
  // open pin pulls up
  wire fmt = lane_format_select_oe ? lane_format_select_out : 1'b1;
  wire jeida = depth_select && !fmt;
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      px_valid <= 1'b0;
      errs <= 8'h00;
      x_reg <= 11'h000;
      gap_reg <= 16'h0000;
      lines_reg <= 10'h000;
    end
    else
    begin
      sc_reg <= {sc_reg[5:0], link_clock_pos};
      s0_reg <= {s0_reg[5:0], lane_pos[0]};
      s1_reg <= {s1_reg[5:0], lane_pos[1]};
      s2_reg <= {s2_reg[5:0], lane_pos[2]};
      s3_reg <= {s3_reg[5:0], lane_pos[3]};
      px_valid <= 1'b0;
      // word aligned to the clock lane pattern, seven slots at one slot a clock
      if (sc_reg == `LPV_CLK_PATTERN)
      begin
        if (line_sync_input || frame_sync_input)
          errs <= errs + 8'h01;
        if (s2_reg[6])
        begin
          if (gap_reg > H_ACTIVE + 300)
          begin
            if (lines_reg != 0 && lines_reg != V_ACTIVE)
              errs <= errs + 8'h01;
            lines_reg <= 10'h000;
          end
          gap_reg <= 16'h0000;
          x_reg <= x_reg + 11'h001;
          px_valid <= 1'b1;
          px_col <= scan_direction_select ?
            11'(H_ACTIVE - 1) - x_reg : x_reg;
          px_rgb <= jeida ? {s0_reg[5:0], t3[1:0], s1_reg[4:0], s0_reg[6],
            t3[3:2], s2_reg[3:0], s1_reg[6:5], t3[5:4]}
            : {t3[1:0], s0_reg[5:0], t3[3:2], s1_reg[4:0], s0_reg[6],
            t3[5:4], s2_reg[3:0], s1_reg[6:5]};
        end
        else
        begin
          gap_reg <= gap_reg + 16'h0001;
          if (x_reg != 0)
          begin
            if (x_reg != H_ACTIVE)
              errs <= errs + 8'h01;
            lines_reg <= lines_reg + 10'h001;
            x_reg <= 11'h000;
          end
        end
      end
    end
  end
endmodule // lpv_panel_model

// File: tb/lpv_host_ctrl_test.sv
// testbench: register set-up, three link formats, power-down
// assumes lpv_host_ctrl driving the panel model; short geometry
`timescale 1ns/1ps
`include "lpv_consts.vh"
module lpv_host_ctrl_test;
  // ----------------------------------------------------------------
  // bench
  // ----------------------------------------------------------------
  localparam H = 4;
  localparam V = 2;
  reg clk, reset, psel, penable, pwrite;
  reg [11:0] paddr;
  reg [31:0] pwdata, rd;
  reg [15:0] k;
  reg [23:0] mask;
  reg er;
  wire [31:0] prdata;
  wire [3:0] lane_pos, lane_neg;
  wire [23:0] px_rgb;
  wire [7:0] errs;
  wire pready, pslverr, pix_ready, frame_start, link_clock_pos;
  wire link_clock_neg, line_sync_input, frame_sync_input, depth_select;
  wire scan_direction_select, lane_format_select_out, px_valid;
  wire lane_format_select_oe, supply_enable, backlight_enable;
  wire [23:0] pix_rgb = {k[7:0], ~k[7:0], k[7:0] ^ 8'h5a};
  logic [23:0] q[$];
  int mismatches = 0;
  int samples_checked = 0;
  int cyc = 0;
  lpv_host_ctrl #(.H_ACTIVE(H), .V_ACTIVE(V)) lpv_host_ctrl_inst (.clk,
    .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .pix_rgb, .pix_ready, .frame_start, .lane_pos, .lane_neg,
    .link_clock_pos, .link_clock_neg, .line_sync_input, .frame_sync_input,
    .depth_select, .scan_direction_select, .lane_format_select_out,
    .lane_format_select_oe, .supply_enable, .backlight_enable);
  lpv_panel_model #(.H_ACTIVE(H), .V_ACTIVE(V)) lpv_panel_model_inst (.clk,
    .reset, .lane_pos, .link_clock_pos, .line_sync_input, .frame_sync_input,
    .depth_select, .scan_direction_select, .lane_format_select_out,
    .lane_format_select_oe, .px_valid, .px_rgb, .px_col(), .errs);
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task test_done;
  begin
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
  begin
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  end
  endtask
  // pixel source and pixel compare
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc > 90000)
    begin
      mismatches++;
      test_done;
    end
    if (pix_ready === 1'b1)
    begin
      k <= k + 16'h0001;
      q.push_back(pix_rgb & mask);
    end
    if (px_valid === 1'b1)
      check({8'h00, px_rgb}, q.size() ? {8'h00, q.pop_front()} : 32'h1000000);
  end
  task apb(input reg w, input reg [11:0] a, input reg [31:0] d);
    int n;
  begin
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 40);
    if (n >= 40)
      mismatches++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask
  task rdchk(input reg [11:0] a, input reg [31:0] exp);
  begin
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  end
  endtask
  task test_reset;
  begin
    check({27'h0, lane_format_select_oe, lane_pos}, 32'h10);
    rdchk(`LPV_OFF_CTRL, 32'h0);
    rdchk(`LPV_OFF_HBLANK, 32'h0b0);
    rdchk(`LPV_OFF_VBLANK, 32'h00a);
    rdchk(12'h014, 32'h0);
    check({31'h0, er}, 32'h1);
    $display("test_reset done");
  end
  endtask
  task test_clamp;
  begin
    apb(1'b1, `LPV_OFF_HBLANK, 32'h0);
    rdchk(`LPV_OFF_HBLANK, 32'h0aa);
    apb(1'b1, `LPV_OFF_HBLANK, 32'h3e7);
    rdchk(`LPV_OFF_HBLANK, 32'h12c);
    apb(1'b1, `LPV_OFF_VBLANK, 32'hc8);
    rdchk(`LPV_OFF_VBLANK, 32'h0a0);
    apb(1'b1, `LPV_OFF_VBLANK, 32'h0);
    rdchk(`LPV_OFF_VBLANK, 32'h00a);
    apb(1'b1, `LPV_OFF_HBLANK, 32'h0aa);
    $display("test_clamp done");
  end
  endtask
  task test_frame(input reg [5:0] c, input reg bl);
    int n, m;
  begin
    mask = c[1] ? 24'hffffff : 24'h3f3f3f;
    apb(1'b1, `LPV_OFF_CTRL, {26'h0, c});
    n = 0;
    while (frame_start !== 1'b1 && n < 40000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 40000)
      mismatches++;
    n = samples_checked;
    m = 0;
    while (samples_checked < n + H * V && m < 40000)
    begin
      @(posedge clk);
      m++;
    end
    if (m >= 40000)
      mismatches++;
    check({24'h0, errs}, 32'h0);
    check({29'h0, depth_select, scan_direction_select,
      lane_format_select_oe}, {29'h0, c[1], c[2], c[3]});
    check({31'h0, backlight_enable}, {31'h0, bl});
    $display("test_frame %h done", c);
  end
  endtask
  task test_off;
    int n;
  begin
    apb(1'b1, `LPV_OFF_CTRL, 32'h30);
    repeat (2) @(posedge clk);
    check({31'h0, backlight_enable}, 32'h0);
    apb(1'b1, `LPV_OFF_CTRL, 32'h0);
    n = 0;
    while (lane_neg !== 4'h0 && n < 16)
    begin
      @(posedge clk);
      n++;
    end
    check({23'h0, lane_pos, lane_neg, link_clock_pos}, 32'h0);
    $display("test_off done");
  end
  endtask
  initial
  begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    k = 16'h0000;
    mask = 24'h0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    test_reset;
    test_clamp;
    test_frame(6'h33, 1'b0);
    test_frame(6'h3f, 1'b1);
    test_frame(6'h31, 1'b1);
    test_off;
    test_done;
  end
endmodule // lpv_host_ctrl_test
